// ===== core/fieldbus_cmd_regs.svh
// constants for the fieldbus command word decoder
//
// Functional notes
// - Fourteen data slots, each with parameter address
// - Holding register address field is 16 bits
// - Five-digit masters reach registers 400001-409999 only
// - 32-bit parameters refused under five-digit numbering
// - Converting or pass-through profile, selectable
// - Bit 0: ready-to-operate, else ramp stop
// - Bit 1 low: coast stop, switch-on inhibited
// - Bit 2 low: emergency stop, switch-on inhibited
// - Bit 3: operation enabled, drives run enable
// - Bit 4 low: ramp output forced zero
// - Bit 5 low: ramp output held
// - Bit 6 low: ramp input zero, if sourced
// - Bit 7 rising edge resets fault, if sourced
// - Bits 8, 9 request jog speeds, if sourced
// - Bit 10 enables control, else retain/lock
// - Bit 11 selects second or first location
// - Bits 12 to 15 are free user bits
`ifndef FIELDBUS_CMD_REGS_SVH
`define FIELDBUS_CMD_REGS_SVH
`define SLOT_COUNT       14
`define SLOT_IDX_W       4
`define ADDR_W           16
`define WORD_W           16
`define FIVE_DIGIT_LIMIT 16'h270F
`define BIT_RAMP_STOP    0
`define BIT_COAST_STOP   1
`define BIT_EMERG_STOP   2
`define BIT_OPERATE      3
`define BIT_RAMP_OUT     4
`define BIT_RAMP_HOLD    5
`define BIT_RAMP_IN      6
`define BIT_FAULT_RESET  7
`define BIT_JOG1         8
`define BIT_JOG2         9
`define BIT_REMOTE       10
`define BIT_LOC_SELECT   11
`define BIT_USER_LO      12
`define CMD_RESET_VALUE  16'h0000
`endif

// ===== core/fieldbus_cmd_pkg.sv
// types for the fieldbus command word decoder
package fieldbus_cmd_pkg;
  // drive state requested by the command word
  typedef enum logic [2:0]
  {
    ST_SWITCH_ON_INHIBITED = 3'b000,
    ST_READY_TO_SWITCH_ON  = 3'b001,
    ST_READY_TO_OPERATE    = 3'b010,
    ST_OPERATION_ENABLED   = 3'b011,
    ST_FIRST_OFF_ACTIVE    = 3'b100,
    ST_SECOND_OFF_ACTIVE   = 3'b101,
    ST_THIRD_OFF_ACTIVE    = 3'b110,
    ST_OPERATION_INHIBITED = 3'b111
  } drive_state_t;
endpackage

// ===== core/slot_address_table.sv
// small memory of the fourteen data slot parameter addresses
`timescale 1ns/1ps
`include "fieldbus_cmd_regs.svh"
module slot_address_table
#(
  parameter int SLOTS = `SLOT_COUNT,
  parameter int AW    = `ADDR_W
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // write port
  input  wire logic                  writeEn,
  input  wire logic [`SLOT_IDX_W-1:0] writeIdx,
  input  wire logic [AW-1:0]         writeAddr,
  input  wire logic                  writeWide,
  // read port, registered
  input  wire logic [`SLOT_IDX_W-1:0] readIdx,
  output logic      [AW-1:0]         readAddr,
  output logic                       readWide
);
  logic [AW-1:0] addrMem [SLOTS];  // configured parameter address per slot
  logic          wideMem [SLOTS];  // slot carries a 32-bit parameter

  // store configuration; out of range index ignored
  always_ff @(posedge clk)
  begin
    if (writeEn && (int'(writeIdx) < SLOTS))
    begin
      addrMem[writeIdx] <= writeAddr;
      wideMem[writeIdx] <= writeWide;
    end
  end

  // registered read, zero for unknown slots
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      readAddr <= '0;
      readWide <= 1'b0;
    end
    else if (int'(readIdx) < SLOTS)
    begin
      readAddr <= addrMem[readIdx];
      readWide <= wideMem[readIdx];
    end
    else
    begin
      readAddr <= '0;
      readWide <= 1'b0;
    end
  end
endmodule

// ===== core/fieldbus_command_word_decoder.sv
// decodes holding register access and the converting-profile command word
`timescale 1ns/1ps
`include "fieldbus_cmd_regs.svh"
module fieldbus_command_word_decoder
  import fieldbus_cmd_pkg::*;
#(
  parameter int SLOTS = `SLOT_COUNT
)
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // slot configuration
  input  wire logic                   slotCfgWrite,
  input  wire logic [`SLOT_IDX_W-1:0] slotCfgIdx,
  input  wire logic [`ADDR_W-1:0]     slotCfgAddr,
  input  wire logic                   slotCfgWide,
  // holding register access from the master side
  input  wire logic                   regAccess,
  input  wire logic [`ADDR_W-1:0]     regAddr,
  input  wire logic                   fiveDigitMode,
  input  wire logic [`SLOT_IDX_W-1:0] regSlot,
  output logic                        accessValid,
  output logic                        accessDenied,
  output logic [`ADDR_W-1:0]          paramAddr,
  // command word write
  input  wire logic                   commandWrite,
  input  wire logic [`WORD_W-1:0]     command_word,
  input  wire logic                   referenceNonZero,
  // configuration
  input  wire logic                   pass_through_profile,
  input  wire logic                   rampInFromBus,
  input  wire logic                   resetFromBus,
  input  wire logic                   jogFromBus,
  input  wire logic                   locationFromBus,
  input  wire logic                   runEnableFromBus,
  input  wire logic                   runEnableExternal,
  input  wire logic                   faultActive,
  // drive requests
  output logic                        ramp_stop_request_n,
  output logic                        coast_stop_request_n,
  output logic                        emergency_stop_request_n,
  output logic                        runEnable,
  output logic                        rampOutZero,
  output logic                        rampHold,
  output logic                        rampInZero,
  output logic                        faultResetPulse,
  output logic                        jogFirst,
  output logic                        jogSecond,
  output logic                        busControlEnabled,
  output logic                        refRampLocked,
  output logic                        external_location_select,
  output logic [3:0]                  userBits,
  output logic [`WORD_W-1:0]          passWord,
  output drive_state_t                driveState
);
  // command word history
  logic [`WORD_W-1:0] cmdReg;       // last sampled command word
  logic [`WORD_W-1:0] prevReg;      // word before that, for edge detection
  logic               newWord_reg;  // a word was sampled last cycle
  // register lookup pipeline
  logic               pendReg;      // register lookup in flight
  logic [`ADDR_W-1:0] pendAddr;     // address of lookup in flight
  logic               pendFive;     // lookup uses five-digit numbering
  logic [`ADDR_W-1:0] slotAddr;     // slot table read data
  logic               slotWide;     // slot holds a 32-bit parameter
  drive_state_t       state_next;   // next requested drive state

  // a bit of the sampled word
  // single-bit output decodes go through here; the state logic indexes cmdReg by the header's bit positions
  function automatic logic cmdBit(input logic [`WORD_W-1:0] w, input int idx);
    cmdBit = w[idx];
  endfunction

  // slot table: parameter address per data slot
  // an index beyond the last slot reads back as zero
  slot_address_table #(.SLOTS(SLOTS), .AW(`ADDR_W)) slotTable
  (
    .clk       (clk),
    .reset     (reset),
    .writeEn   (slotCfgWrite),
    .writeIdx  (slotCfgIdx),
    .writeAddr (slotCfgAddr),
    .writeWide (slotCfgWide),
    .readIdx   (regSlot),
    .readAddr  (slotAddr),
    .readWide  (slotWide)
  );

  // hold the request while the slot table answers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pendReg  <= 1'b0;
      pendAddr <= '0;
      pendFive <= 1'b0;
    end
    else
    begin
      // a request stands one cycle; its qualifiers are captured with it
      pendReg  <= regAccess;
      pendAddr <= regAddr;          // full 16-bit field
      pendFive <= fiveDigitMode;
    end
  end

  // answer a register access one cycle after the slot read
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      accessValid  <= 1'b0;
      accessDenied <= 1'b0;
      paramAddr    <= '0;
    end
    else if (pendReg)
    begin
      // five-digit masters only reach offsets 0..9998
      if (pendFive && ((pendAddr >= `FIVE_DIGIT_LIMIT) || slotWide))
      begin
        // refused: the last granted address stays on paramAddr
        accessValid  <= 1'b0;
        accessDenied <= 1'b1;
      end
      else
      begin
        // granted: hand on the slot's parameter address
        accessValid  <= 1'b1;
        accessDenied <= 1'b0;
        paramAddr    <= slotAddr;
      end
    end
    else
    begin
      // no lookup: both answers low
      accessValid  <= 1'b0;
      accessDenied <= 1'b0;
    end
  end

  // sample the command word once per completed write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cmdReg      <= `CMD_RESET_VALUE;
      prevReg     <= `CMD_RESET_VALUE;
      newWord_reg <= 1'b0;
    end
    else
    begin
      newWord_reg <= commandWrite;
      if (commandWrite)
      begin
        // the old word is kept for the bit 7 edge test
        prevReg <= cmdReg;
        cmdReg  <= command_word;
      end
    end
  end

  // converting profile decode; pass-through copies the word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ramp_stop_request_n      <= 1'b0;
      coast_stop_request_n     <= 1'b0;
      emergency_stop_request_n <= 1'b0;
      runEnable                <= 1'b0;
      rampOutZero              <= 1'b1;
      rampHold                 <= 1'b1;
      rampInZero               <= 1'b1;
      jogFirst                 <= 1'b0;
      jogSecond                <= 1'b0;
      busControlEnabled        <= 1'b0;
      refRampLocked            <= 1'b1;
      external_location_select <= 1'b0;
      userBits                 <= 4'h0;
      passWord                 <= `CMD_RESET_VALUE;
    end
    else
    begin
      // the raw word shows only in pass-through, zero otherwise
      passWord <= pass_through_profile ? cmdReg : `CMD_RESET_VALUE;
      if (pass_through_profile)
      begin
        // conversion off: drive takes the raw word
        ramp_stop_request_n      <= 1'b0;
        coast_stop_request_n     <= 1'b0;
        emergency_stop_request_n <= 1'b0;
        runEnable                <= 1'b0;
        jogFirst                 <= 1'b0;
        jogSecond                <= 1'b0;
      end
      else
      begin
        // stop requests are active low, a cleared bit asks for the stop
        ramp_stop_request_n      <= cmdBit(cmdReg, `BIT_RAMP_STOP);
        coast_stop_request_n     <= cmdBit(cmdReg, `BIT_COAST_STOP);
        emergency_stop_request_n <= cmdBit(cmdReg, `BIT_EMERG_STOP);
        // bit drives run enable when sourced from the bus
        runEnable <= runEnableFromBus ? cmdBit(cmdReg, `BIT_OPERATE) : runEnableExternal;
        // ramp generator controls: a cleared bit forces or holds
        rampOutZero <= ~cmdBit(cmdReg, `BIT_RAMP_OUT);
        rampHold    <= ~cmdBit(cmdReg, `BIT_RAMP_HOLD);
        rampInZero  <= rampInFromBus & ~cmdBit(cmdReg, `BIT_RAMP_IN);
        jogFirst    <= jogFromBus & cmdBit(cmdReg, `BIT_JOG1);
        jogSecond   <= jogFromBus & cmdBit(cmdReg, `BIT_JOG2);
        busControlEnabled <= cmdBit(cmdReg, `BIT_REMOTE);
        // locked only when word and reference are both zero
        refRampLocked <= ~cmdBit(cmdReg, `BIT_REMOTE) & (cmdReg == '0) & ~referenceNonZero;
        if (locationFromBus)
        begin
          external_location_select <= cmdBit(cmdReg, `BIT_LOC_SELECT);
        end
        userBits <= cmdReg[`BIT_USER_LO +: 4];
      end
    end
  end

  // fault reset on rising bit 7 against the previous word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      faultResetPulse <= 1'b0;
    end
    else
    begin
      // only a fresh word may fire, so a held bit 7 never repeats the pulse
      faultResetPulse <= newWord_reg && !pass_through_profile && resetFromBus
                         && cmdBit(cmdReg, `BIT_FAULT_RESET)
                         && !cmdBit(prevReg, `BIT_FAULT_RESET);
    end
  end

  // next requested drive state
  always_comb
  begin
    // hold the state unless a transition fires
    state_next = driveState;
    case (driveState)
      // leave inhibit only with both fast stops released and bit 0 low
      ST_SWITCH_ON_INHIBITED:
        if (cmdReg[`BIT_COAST_STOP] && cmdReg[`BIT_EMERG_STOP] && !cmdReg[`BIT_RAMP_STOP])
          state_next = ST_READY_TO_SWITCH_ON;
      // bit 0 high moves on toward ready-to-operate
      ST_READY_TO_SWITCH_ON:
        if (cmdReg[`BIT_RAMP_STOP])
          state_next = ST_READY_TO_OPERATE;
      // bit 0 low falls back; bit 3 with run enable starts operation
      ST_READY_TO_OPERATE, ST_OPERATION_INHIBITED:
        if (!cmdReg[`BIT_RAMP_STOP])
          state_next = ST_READY_TO_SWITCH_ON;
        else if (cmdReg[`BIT_OPERATE] && runEnable)
          state_next = ST_OPERATION_ENABLED;
      // running: bit 0 low ramps down, bit 3 low inhibits
      ST_OPERATION_ENABLED:
        if (!cmdReg[`BIT_RAMP_STOP])
          state_next = ST_FIRST_OFF_ACTIVE;
        else if (!cmdReg[`BIT_OPERATE] || !runEnable)
          state_next = ST_OPERATION_INHIBITED;
      // ramp stop done, ready to switch on again
      ST_FIRST_OFF_ACTIVE:
        state_next = ST_READY_TO_SWITCH_ON;
      // coast and emergency stops end in switch-on inhibited
      ST_SECOND_OFF_ACTIVE, ST_THIRD_OFF_ACTIVE:
        state_next = ST_SWITCH_ON_INHIBITED;
      // unused code, back to the safe state
      default:
        state_next = ST_SWITCH_ON_INHIBITED;
    endcase
    // coast and emergency stop override from any live state
    if (driveState != ST_SWITCH_ON_INHIBITED && driveState != ST_SECOND_OFF_ACTIVE
        && driveState != ST_THIRD_OFF_ACTIVE)
    begin
      if (!cmdReg[`BIT_COAST_STOP])
        state_next = ST_SECOND_OFF_ACTIVE;
      else if (!cmdReg[`BIT_EMERG_STOP])
        state_next = ST_THIRD_OFF_ACTIVE;
    end
  end

  // state register; fault reset forces switch-on inhibited
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // every power-up starts inhibited
      driveState <= ST_SWITCH_ON_INHIBITED;
    end
    else if (faultResetPulse && faultActive)
    begin
      // an acknowledged fault always lands in switch-on inhibited
      driveState <= ST_SWITCH_ON_INHIBITED;
    end
    else if (!pass_through_profile)
    begin
      // one transition per clock; pass-through leaves the state frozen
      driveState <= state_next;
    end
  end
endmodule

// ===== testbench/fieldbus_cmd_sva.sv
// assertion checker for the fieldbus command word decoder
`timescale 1ns/1ps
`include "fieldbus_cmd_regs.svh"
module fieldbus_cmd_sva
#(
  parameter int SLOTS = `SLOT_COUNT
)
(
  // requests
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               regAccess,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic               fiveDigitMode,
  input wire logic               commandWrite,
  input wire logic [`WORD_W-1:0] command_word,
  input wire logic               pass_through_profile,
  input wire logic               resetFromBus,
  // answers
  input wire logic               accessValid,
  input wire logic               accessDenied,
  input wire logic               ramp_stop_request_n,
  input wire logic               coast_stop_request_n,
  input wire logic               emergency_stop_request_n,
  input wire logic               rampOutZero,
  input wire logic               rampHold,
  input wire logic               busControlEnabled,
  input wire logic [3:0]         userBits,
  input wire logic [`WORD_W-1:0] passWord,
  input wire logic               faultResetPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // each request gets exactly one answer two cycles on
  property p_answer; regAccess |-> ##2 (accessValid != accessDenied); endproperty
  a_answer: assert property (p_answer) else $error("access not answered");
  property p_cause; (accessValid || accessDenied) |-> $past(regAccess, 2); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_five; regAccess && fiveDigitMode && regAddr >= `FIVE_DIGIT_LIMIT |-> ##2 accessDenied;
  endproperty
  a_five: assert property (p_five) else $error("high register granted");
  property p_six; regAccess && !fiveDigitMode |-> ##2 accessValid; endproperty
  a_six: assert property (p_six) else $error("six-digit access refused");
  // converting-profile bits and the pass-through word reach their outputs two cycles after the write
  property p_stops; commandWrite && !pass_through_profile |-> ##2
    {emergency_stop_request_n, coast_stop_request_n, ramp_stop_request_n}
    == $past(command_word[2:0], 2); endproperty
  a_stops: assert property (p_stops) else $error("stop requests wrong");
  property p_ramp; commandWrite && !pass_through_profile |-> ##2
    rampOutZero == !$past(command_word[4], 2) && rampHold == !$past(command_word[5], 2);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp controls wrong");
  property p_ctl; commandWrite && !pass_through_profile |-> ##2
    busControlEnabled == $past(command_word[10], 2) && userBits == $past(command_word[15:12], 2);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control or user bits wrong");
  property p_pass; commandWrite && pass_through_profile |-> ##2 passWord == $past(command_word, 2);
  endproperty
  a_pass: assert property (p_pass) else $error("pass word wrong");
  // a fault reset pulse needs a sourced write with bit 7 set and lasts one cycle
  property p_pulse; faultResetPulse |-> $past(commandWrite, 2) && $past(command_word[7], 2)
    && $past(resetFromBus, 2) ##1 !faultResetPulse; endproperty
  a_pulse: assert property (p_pulse) else $error("fault reset pulse wrong");
  c_denied: cover property (accessDenied);
  c_pulse: cover property (faultResetPulse);
  c_pass: cover property (commandWrite && pass_through_profile);
endmodule
bind fieldbus_command_word_decoder fieldbus_cmd_sva #(.SLOTS(SLOTS)) fieldbus_cmd_sva_inst (.*);

// ===== testbench/fieldbus_master_model.sv
// behavioural fieldbus master issuing slot, register and command requests
`timescale 1ns/1ps
`include "fieldbus_cmd_regs.svh"
module fieldbus_master_model
(
  // clock
  input wire logic                clk,
  // requests
  output logic                    slotCfgWrite,
  output logic [`SLOT_IDX_W-1:0]  slotCfgIdx,
  output logic [`ADDR_W-1:0]      slotCfgAddr,
  output logic                    slotCfgWide,
  output logic                    regAccess,
  output logic [`ADDR_W-1:0]      regAddr,
  output logic [`SLOT_IDX_W-1:0]  regSlot,
  output logic                    commandWrite,
  output logic [`WORD_W-1:0]      command_word
);
  // idle, nothing requested
  initial
  begin
    {slotCfgWrite, slotCfgIdx, slotCfgAddr, slotCfgWide} = '0;
    {regAccess, regAddr, regSlot, commandWrite, command_word} = '0;
  end
  // each request stands one cycle; released data shows inverted
  task automatic cfg_slot(input logic [3:0] i, input logic [15:0] a, input logic w);
    @(negedge clk);
    {slotCfgWrite, slotCfgIdx, slotCfgAddr, slotCfgWide} = {1'b1, i, a, w};
    @(negedge clk);
    slotCfgWrite = 1'b0;
    slotCfgAddr = ~a;
  endtask
  // zero-based offset, 400001 is offset 0
  task automatic request(input logic [15:0] a, input logic [3:0] s);
    @(negedge clk);
    {regAccess, regAddr, regSlot} = {1'b1, a, s};
    @(negedge clk);
    regAccess = 1'b0;
    regAddr = ~a;
  endtask
  // whole packed 16-bit word per write
  task automatic command(input logic [15:0] w);
    @(negedge clk);
    {commandWrite, command_word} = {1'b1, w};
    @(negedge clk);
    commandWrite = 1'b0;
    command_word = ~w;
  endtask
endmodule

// ===== testbench/fieldbus_command_word_decoder_tb.sv
// self-checking bench for the fieldbus command word decoder
`timescale 1ns/1ps
`include "fieldbus_cmd_regs.svh"
module fieldbus_command_word_decoder_tb
  import fieldbus_cmd_pkg::*;
;
  // configuration levels and clock
  logic clk, reset, fiveDigitMode, referenceNonZero, pass_through_profile, faultActive;
  logic rampInFromBus, resetFromBus, jogFromBus, locationFromBus, runEnableFromBus;
  logic runEnableExternal;
  // request lines from the master model
  logic slotCfgWrite, slotCfgWide, regAccess, commandWrite;
  logic [3:0] slotCfgIdx, regSlot, userBits;
  logic [15:0] slotCfgAddr, regAddr, command_word, paramAddr, passWord;
  // decoder answers
  logic accessValid, accessDenied, ramp_stop_request_n, coast_stop_request_n;
  logic emergency_stop_request_n, runEnable, rampOutZero, rampHold, rampInZero;
  logic faultResetPulse, jogFirst, jogSecond, busControlEnabled, refRampLocked;
  logic external_location_select;
  drive_state_t driveState;
  int errCount = 0;
  int cmpCount = 0;
  logic [15:0] lastGrant = 16'h0000;
  logic [15:0] words [5] = '{16'hFFFF, 16'hA5A5, 16'h5A5A, 16'h0800, 16'h0000};
  fieldbus_command_word_decoder fieldbus_command_word_decoder_inst (.*);
  fieldbus_master_model fieldbus_master_model_inst (.*);
  always #12.5 clk = ~clk;
  // compares one value and counts
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // register request; answer looked at in its one standing cycle, address held when refused
  task automatic access(input logic [15:0] a, input logic five, input logic [3:0] s,
                        input logic ok);
    fiveDigitMode = five;
    fieldbus_master_model_inst.request(a, s);
    @(negedge clk);
    if (ok)
      lastGrant = 16'h1000 + 16'(s);
    check(accessValid, ok);
    check(accessDenied, !ok);
    check(paramAddr, lastGrant);
  endtask
  // command write; returns while the fault reset pulse still stands
  task automatic cmd(input logic [15:0] w);
    fieldbus_master_model_inst.command(w);
    @(negedge clk);
  endtask
  task automatic decoded(input logic [15:0] w);
    cmd(w);
    check(ramp_stop_request_n, w[0]);
    check(coast_stop_request_n, w[1]);
    check(emergency_stop_request_n, w[2]);
    check(runEnable, w[3]);
    check({rampInZero, rampHold, rampOutZero}, {~w[6], ~w[5], ~w[4]});
    check({jogSecond, jogFirst}, w[9:8]);
    check(refRampLocked, !w[10] && w == 16'h0000 && !referenceNonZero);
    check(busControlEnabled, w[10]);
    check(external_location_select, w[11]);
    check(userBits, w[15:12]);
  endtask
  // cuts a hang short
  initial
  begin
    #200000;
    errCount++;
    report_and_stop;
  end
  initial
  begin
    {clk, fiveDigitMode, referenceNonZero, pass_through_profile, faultActive} = '0;
    {rampInFromBus, resetFromBus, jogFromBus, locationFromBus, runEnableFromBus} = '1;
    {runEnableExternal, reset} = 2'h1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(driveState, ST_SWITCH_ON_INHIBITED);
    check({refRampLocked, rampOutZero, ramp_stop_request_n}, 3'h6);
    reset = 1'b0;
    for (int i = 0; i < `SLOT_COUNT; i++)
    begin
      // only the last slot carries a 32-bit parameter
      fieldbus_master_model_inst.cfg_slot(i[3:0], 16'h1000 + 16'(i),
                                          i == `SLOT_COUNT - 1);
    end
    access(16'h0000, 1'b1, 4'h0, 1'b1);
    access(16'h270E, 1'b1, 4'h1, 1'b1);
    access(16'h270F, 1'b1, 4'h2, 1'b0);
    access(16'h0005, 1'b1, 4'hD, 1'b0);
    access(16'hFFFF, 1'b0, 4'h3, 1'b1);
    access(16'h0005, 1'b0, 4'hD, 1'b1);
    foreach (words[k])
      decoded(words[k]);
    referenceNonZero = 1'b1;
    decoded(16'h0000);
    {locationFromBus, jogFromBus} = 2'h0;
    cmd(16'h0B00);
    check({external_location_select, jogSecond, jogFirst}, 3'h0);
    // walk the requested drive state up to operation enabled
    cmd(16'h0006);
    check(driveState, ST_READY_TO_SWITCH_ON);
    cmd(16'h000F);
    check(driveState, ST_READY_TO_OPERATE);
    @(negedge clk);
    check(driveState, ST_OPERATION_ENABLED);
    // bit 7 rises with bit 3 dropped: inhibit first, then the fault reset wins
    faultActive = 1'b1;
    cmd(16'h0087);
    check(faultResetPulse, 1'b1);
    check(driveState, ST_OPERATION_INHIBITED);
    @(negedge clk);
    check(driveState, ST_SWITCH_ON_INHIBITED);
    cmd(16'h0080);
    check(faultResetPulse, 1'b0);
    // run enable from outside, ramp input not sourced from the bus
    {runEnableFromBus, runEnableExternal, rampInFromBus} = 3'h2;
    cmd(16'h0000);
    check({runEnable, rampInZero}, 2'h2);
    resetFromBus = 1'b0;
    cmd(16'h0080);
    check(faultResetPulse, 1'b0);
    pass_through_profile = 1'b1;
    cmd(16'h1235);
    check(passWord, 16'h1235);
    check(ramp_stop_request_n, 1'b0);
    report_and_stop;
  end
endmodule
